/* File: hdl/spd_pkg.sv */
// Shared constants and types for the DDR4 command, address and data decoder
package spd_pkg;
  localparam int ADDR_W = 14;
  localparam int ROW_W  = 17;
  localparam int COL_W  = 10;
  localparam int DQ_W   = 16;
  localparam int AUTO_CLOSE_POS  = 10;
  localparam int BURST_HALVE_POS = 12;
  localparam logic [2:0] MR_ONE_SEL  = 3'h1;
  localparam logic [2:0] MR_FIVE_SEL = 3'h5;
  localparam int NOMINAL_TERMINATION_LSB  = 8;
  localparam int NOMINAL_TERMINATION_MSB  = 10;
  localparam int MR5_DM_POS   = 10;
  localparam int MR5_WDBI_POS = 11;
  localparam int MR5_RDBI_POS = 12;
  localparam logic [ADDR_W-1:0] MR_RESET = 14'h0000;
  localparam logic [2:0] PAIRS_FULL = 3'h4;
  localparam logic [2:0] PAIRS_CHOP = 3'h2;
  localparam logic [3:0] DBI_ZERO_LIMIT = 4'h4;

  typedef enum logic [3:0] {
    SPD_NONE, SPD_ACT, SPD_RD, SPD_WR, SPD_PRE, SPD_PREA,
    SPD_REF, SPD_MRS, SPD_ZQC, SPD_NOP, SPD_RSVD
  } spd_cmd_t;

  typedef struct packed {
    logic              cke;
    logic              cs_n;
    logic              act_n;
    logic              row_hi;
    logic              col;
    logic              store;
    logic              group;
    logic [1:0]        bank;
    logic [ADDR_W-1:0] addr;
  } spd_pins_t;

  typedef struct packed {
    spd_cmd_t          cmd;
    logic              group;
    logic [1:0]        bank;
    logic [ROW_W-1:0]  row;
    logic [COL_W-1:0]  col;
    logic              auto_close;
    logic              burst_full;
    logic [2:0]        mr_sel;
    logic [ADDR_W-1:0] opcode;
  } spd_dec_t;

  typedef struct packed {
    logic [DQ_W-1:0] dq;
    logic [1:0]      strobe;
    logic [1:0]      mask;
  } spd_term_t;

  typedef struct packed {
    logic [1:0][DQ_W-1:0] data;
    logic [3:0]           be;
  } spd_wr_t;
endpackage

/* File: hdl/spd_pin_decode.sv */
// DDR4 command, address, termination and data-qualifier pin decoder
`timescale 1ns/1ns
module spd_pin_decode (
  // Clocks and reset
  input  logic              sys_clk_i,
  input  logic              link_clk_i,
  input  logic              rst_n_i,
  // Command and address pins
  input  logic              cke_i,
  input  logic              chip_sel_n_i,
  input  logic              row_open_strobe_n_i,
  input  logic              cmd_bit_row_hi_i,
  input  logic              cmd_bit_col_i,
  input  logic              cmd_bit_store_i,
  input  logic              group_select_i,
  input  logic              group_select_hi_i,
  input  logic [1:0]        bank_select_i,
  input  logic [13:0]       addr_i,
  input  logic              die_termination_enable_i,
  // Data and mask pins
  input  logic [15:0]       dq_i,
  output logic [15:0]       dq_o,
  output logic              dq_oe_o,
  input  logic              lower_byte_mask_n_i,
  output logic              lower_byte_mask_n_o,
  output logic              lower_byte_mask_oe_o,
  input  logic              upper_byte_mask_n_i,
  output logic              upper_byte_mask_n_o,
  output logic              upper_byte_mask_oe_o,
  // Array side, link clock
  output spd_pkg::spd_dec_t  dec_o,
  output spd_pkg::spd_term_t term_o,
  output logic              wr_valid_o,
  output spd_pkg::spd_wr_t   wr_beats_o,
  input  logic              rd_valid_i,
  input  logic [15:0]       rd_data_i,
  output logic [13:0]       mode_reg_one_o,
  output logic [13:0]       mode_reg_five_o,
  // System side, system clock
  output logic              sys_cmd_valid_o,
  output spd_pkg::spd_dec_t  sys_cmd_o,
  output logic              sys_overrun_o
);
  import spd_pkg::*;

  // ==========================================================
  // Helpers
  function automatic spd_dec_t spd_decode(input spd_pins_t p);
    spd_dec_t d;
    d = '0;
    d.cmd = SPD_NONE;
    d.group = p.group;
    d.bank = p.bank;
    d.row = {p.row_hi, p.col, p.store, p.addr};
    d.col = p.addr[COL_W-1:0];
    d.auto_close = p.addr[AUTO_CLOSE_POS];
    d.burst_full = p.addr[BURST_HALVE_POS];
    d.mr_sel = {p.group, p.bank};
    d.opcode = p.addr;
    // Command only counts with clock enable high
    if (p.cke && !p.cs_n) begin
      if (!p.act_n) begin
        d.cmd = SPD_ACT;
      end else begin
        case ({p.row_hi, p.col, p.store})
          3'h0: d.cmd = SPD_MRS;
          3'h1: d.cmd = SPD_REF;
          3'h2: d.cmd = p.addr[AUTO_CLOSE_POS] ? SPD_PREA
                                               : SPD_PRE;
          3'h4: d.cmd = SPD_WR;
          3'h5: d.cmd = SPD_RD;
          3'h6: d.cmd = SPD_ZQC;
          3'h7: d.cmd = SPD_NOP;
          default: d.cmd = SPD_RSVD;
        endcase
      end
    end
    return d;
  endfunction

  // Write lane: {keep, byte}; inversion wins over mask if both set
  function automatic logic [8:0] spd_lane_in(input logic [7:0] d,
                                             input logic pin_n,
                                             input logic [13:0] mr5);
    logic [8:0] r;
    r = {1'b1, d};
    if (mr5[MR5_WDBI_POS] && !pin_n) begin
      r[7:0] = ~d;
    end else if (mr5[MR5_DM_POS] && !pin_n) begin
      r[8] = 1'b0;
    end
    return r;
  endfunction

  // Read lane: {flag_n, byte}; invert when zeros exceed the limit
  function automatic logic [8:0] spd_lane_out(input logic [7:0] d);
    logic [3:0] z;
    z = 4'h0;
    for (int i = 0; i < 8; i++) begin
      z = z + {3'h0, ~d[i]};
    end
    if (z > DBI_ZERO_LIMIT) begin
      return {1'b0, ~d};
    end
    return {1'b1, d};
  endfunction

  // ==========================================================
  // Pin capture and decode, link clock
  spd_pins_t pins;
  spd_dec_t  next_dec;
  logic      rtt_on;
  logic      unused_group_hi;

  assign pins = '{cke: cke_i, cs_n: chip_sel_n_i,
                  act_n: row_open_strobe_n_i, row_hi: cmd_bit_row_hi_i,
                  col: cmd_bit_col_i, store: cmd_bit_store_i,
                  group: group_select_i, bank: bank_select_i,
                  addr: addr_i};
  assign next_dec = spd_decode(pins);
  // Upper group input has no bank group behind it
  assign unused_group_hi = group_select_hi_i;
  assign rtt_on = mode_reg_one_o[NOMINAL_TERMINATION_MSB:NOMINAL_TERMINATION_LSB] != 3'h0;

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dec_o <= '0;
    end else begin
      dec_o <= next_dec;
    end
  end

  // ==========================================================
  // Mode registers
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg_one_o  <= MR_RESET;
      mode_reg_five_o <= MR_RESET;
    end else if (dec_o.cmd == SPD_MRS) begin
      if (dec_o.mr_sel == MR_ONE_SEL) begin
        mode_reg_one_o <= dec_o.opcode;
      end
      if (dec_o.mr_sel == MR_FIVE_SEL) begin
        mode_reg_five_o <= dec_o.opcode;
      end
    end
  end

  // ==========================================================
  // Termination
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      term_o <= '0;
    end else begin
      // Input ignored while nominal value is off
      term_o <= {($bits(spd_term_t)){die_termination_enable_i &&
                                      rtt_on}};
    end
  end

  // ==========================================================
  // Write data path
  logic [2:0]      wr_left;
  logic            pend;
  logic [DQ_W-1:0] rise_d;
  logic [DQ_W-1:0] fall_d;
  logic [1:0]      rise_m;
  logic [1:0]      fall_m;
  logic [8:0]      ln0;
  logic [8:0]      ln1;
  logic [8:0]      ln2;
  logic [8:0]      ln3;

  // Falling beat held for the next rising edge
  always_ff @(negedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fall_d <= '0;
      fall_m <= 2'h3;
    end else begin
      fall_d <= dq_i;
      fall_m <= {upper_byte_mask_n_i, lower_byte_mask_n_i};
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_left <= 3'h0;
    end else if (next_dec.cmd == SPD_WR) begin
      wr_left <= next_dec.burst_full ? PAIRS_FULL
                                     : PAIRS_CHOP;
    end else if (wr_left != 3'h0) begin
      wr_left <= wr_left - 3'h1;
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend   <= 1'b0;
      rise_d <= '0;
      rise_m <= 2'h3;
    end else begin
      pend   <= wr_left != 3'h0;
      rise_d <= dq_i;
      rise_m <= {upper_byte_mask_n_i, lower_byte_mask_n_i};
    end
  end

  assign ln0 = spd_lane_in(rise_d[7:0], rise_m[0], mode_reg_five_o);
  assign ln1 = spd_lane_in(rise_d[15:8], rise_m[1], mode_reg_five_o);
  assign ln2 = spd_lane_in(fall_d[7:0], fall_m[0], mode_reg_five_o);
  assign ln3 = spd_lane_in(fall_d[15:8], fall_m[1], mode_reg_five_o);

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_valid_o <= 1'b0;
      wr_beats_o <= '0;
    end else begin
      wr_valid_o <= pend;
      wr_beats_o.data[0] <= {ln1[7:0], ln0[7:0]};
      wr_beats_o.data[1] <= {ln3[7:0], ln2[7:0]};
      wr_beats_o.be <= {ln3[8], ln2[8], ln1[8], ln0[8]};
    end
  end

  // ==========================================================
  // Read data path, one beat per rising edge
  logic [8:0] ro0;
  logic [8:0] ro1;
  logic       rdbi;

  assign ro0 = spd_lane_out(rd_data_i[7:0]);
  assign ro1 = spd_lane_out(rd_data_i[15:8]);
  assign rdbi = mode_reg_five_o[MR5_RDBI_POS];

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dq_o                 <= '0;
      dq_oe_o              <= 1'b0;
      lower_byte_mask_n_o  <= 1'b1;
      upper_byte_mask_n_o  <= 1'b1;
      lower_byte_mask_oe_o <= 1'b0;
      upper_byte_mask_oe_o <= 1'b0;
    end else begin
      dq_oe_o              <= rd_valid_i;
      lower_byte_mask_oe_o <= rd_valid_i && rdbi;
      upper_byte_mask_oe_o <= rd_valid_i && rdbi;
      if (rdbi) begin
        dq_o                <= {ro1[7:0], ro0[7:0]};
        lower_byte_mask_n_o <= ro0[8];
        upper_byte_mask_n_o <= ro1[8];
      end else begin
        dq_o                <= rd_data_i;
        lower_byte_mask_n_o <= 1'b1;
        upper_byte_mask_n_o <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Command hand-off to system clock
  // Link runs faster than the system clock, so a busy hand-off
  // drops the command and raises a sticky overrun instead of stalling
  spd_dec_t xfer;
  logic     req;
  logic     ack_l1;
  logic     ack_l2;
  logic     ovr;
  logic     send;
  logic     busy;
  logic     ack_s;

  assign busy = req ^ ack_l2;
  assign send = next_dec.cmd != SPD_NONE && next_dec.cmd != SPD_NOP;

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xfer <= '0;
      req  <= 1'b0;
      ovr  <= 1'b0;
    end else if (send) begin
      if (busy) begin
        ovr <= 1'b1;
      end else begin
        xfer <= next_dec;
        req  <= ~req;
      end
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_l1 <= 1'b0;
      ack_l2 <= 1'b0;
    end else begin
      ack_l1 <= ack_s;
      ack_l2 <= ack_l1;
    end
  end

  // ==========================================================
  // System clock side
  logic req_s1;
  logic req_s2;
  logic ovr_s1;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_s1        <= 1'b0;
      req_s2        <= 1'b0;
      ack_s         <= 1'b0;
      ovr_s1        <= 1'b0;
      sys_overrun_o <= 1'b0;
    end else begin
      req_s1        <= req;
      req_s2        <= req_s1;
      ack_s         <= req_s2;
      ovr_s1        <= ovr;
      sys_overrun_o <= ovr_s1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sys_cmd_valid_o <= 1'b0;
      sys_cmd_o       <= '0;
    end else begin
      sys_cmd_valid_o <= req_s2 ^ ack_s;
      if (req_s2 ^ ack_s) begin
        sys_cmd_o <= xfer;
      end
    end
  end

  // ==========================================================
  // Checks, link clock
  chk_cs_mask: assert property (
    @(posedge link_clk_i) disable iff (!rst_n_i)
    chip_sel_n_i |=> dec_o.cmd == SPD_NONE)
    else $error("command not masked by chip select");

  chk_act_row: assert property (
    @(posedge link_clk_i) disable iff (!rst_n_i)
    (cke_i && !chip_sel_n_i && !row_open_strobe_n_i) |=>
    (dec_o.cmd == SPD_ACT && dec_o.row ==
     {$past(cmd_bit_row_hi_i), $past(cmd_bit_col_i),
      $past(cmd_bit_store_i), $past(addr_i)}))
    else $error("activate row address wrong");

  chk_read_code: assert property (
    @(posedge link_clk_i) disable iff (!rst_n_i)
    (cke_i && !chip_sel_n_i && row_open_strobe_n_i &&
     cmd_bit_row_hi_i && !cmd_bit_col_i && cmd_bit_store_i) |=>
    dec_o.cmd == SPD_RD)
    else $error("read not decoded");

  chk_bank_route: assert property (
    @(posedge link_clk_i) disable iff (!rst_n_i)
    next_dec.cmd == SPD_ACT |=>
    (dec_o.group == $past(group_select_i) &&
     dec_o.bank == $past(bank_select_i)))
    else $error("bank group or bank not routed");

  chk_term_gate: assert property (
    @(posedge link_clk_i) disable iff (!rst_n_i)
    (!rtt_on && $stable(mode_reg_one_o)) |=> term_o == '0)
    else $error("termination on while disabled");

  chk_term_on: assert property (
    @(posedge link_clk_i) disable iff (!rst_n_i)
    (die_termination_enable_i && rtt_on) |=> &term_o)
    else $error("termination not applied to all pins");

  chk_pre_all: assert property (
    @(posedge link_clk_i) disable iff (!rst_n_i)
    (next_dec.cmd inside {SPD_PRE, SPD_PREA}) |=>
    (dec_o.cmd == SPD_PREA) == $past(addr_i[AUTO_CLOSE_POS]))
    else $error("precharge scope wrong");

  chk_burst_len: assert property (
    @(posedge link_clk_i) disable iff (!rst_n_i)
    dec_o.cmd == SPD_WR |->
    wr_left == (dec_o.burst_full ? PAIRS_FULL : PAIRS_CHOP))
    else $error("burst length not loaded");

  chk_mrs_load: assert property (
    @(posedge link_clk_i) disable iff (!rst_n_i)
    (dec_o.cmd == SPD_MRS && dec_o.mr_sel == MR_ONE_SEL) |=>
    mode_reg_one_o == $past(dec_o.opcode))
    else $error("mode register one not loaded");

  chk_mask_drop: assert property (
    @(posedge link_clk_i) disable iff (!rst_n_i)
    (wr_left != 3'h0 && !lower_byte_mask_n_i &&
     mode_reg_five_o[MR5_DM_POS] && !mode_reg_five_o[MR5_WDBI_POS] &&
     next_dec.cmd != SPD_MRS && dec_o.cmd != SPD_MRS) |=>
    ##1 (wr_valid_o && !wr_beats_o.be[0]))
    else $error("masked byte kept");

  chk_rd_invert: assert property (
    @(posedge link_clk_i) disable iff (!rst_n_i)
    (lower_byte_mask_oe_o && !lower_byte_mask_n_o) |->
    dq_o[7:0] == ~$past(rd_data_i[7:0]))
    else $error("read byte not inverted");

  cov_act: cover property (
    @(posedge link_clk_i) disable iff (!rst_n_i)
    dec_o.cmd == SPD_ACT);
  cov_wr_burst: cover property (
    @(posedge link_clk_i) disable iff (!rst_n_i)
    dec_o.cmd == SPD_WR ##1 wr_left != 3'h0 ##2 wr_valid_o);
  cov_mrs: cover property (
    @(posedge link_clk_i) disable iff (!rst_n_i)
    dec_o.cmd == SPD_MRS);
  cov_overrun: cover property (
    @(posedge link_clk_i) disable iff (!rst_n_i)
    send && busy);
endmodule // spd_pin_decode

/* File: test/spd_ctrl_model.sv */
// Controller-side model driving command, address and write data pins
`timescale 1ns/1ns
module spd_ctrl_model (
  // Clock
  input  logic               clk_i,
  // Pins toward the device
  output spd_pkg::spd_pins_t pins_o,
  output logic [15:0]        dq_o,
  output logic [1:0]         mask_n_o
);
  import spd_pkg::*;
  // ====
  // Pin drivers
  // Deselected pins show the inverse of their last value, except cke and cs_n, which are driven high
  task automatic idle();
    spd_pins_t p;
    p      = ~pins_o;
    p.cs_n = 1'b1;
    p.cke  = 1'b1;
    pins_o = p;
  endtask
  task automatic cmd(input spd_pins_t p);
    @(posedge clk_i);
    #2;
    pins_o = p;
    @(posedge clk_i);
    #2;
    idle();
  endtask
  // Every half beat carries its own mask value
  task automatic wr_data(input logic [7:0][15:0] d,
                         input logic [7:0][1:0] m, input int n);
    for (int i = 0; i < n; i++) begin
      if (i % 2 == 0)
        @(negedge clk_i);
      else
        @(posedge clk_i);
      #2;
      dq_o     = d[i];
      mask_n_o = m[i];
    end
    @(negedge clk_i);
    #2;
    dq_o     = ~dq_o;
    mask_n_o = ~mask_n_o;
  endtask
  initial begin
    pins_o   = '1;
    dq_o     = 16'h0000;
    mask_n_o = 2'h3;
  end
endmodule // spd_ctrl_model

/* File: test/testbench.sv */
// Self-checking bench for the DDR4 pin decoder
`timescale 1ns/1ns
module testbench;
  import spd_pkg::*;
  // ====
  // Signals
  localparam logic [7:0][15:0] WD = {16'hf00f, 16'h3c5a, 16'h0123,
    16'hfedc, 16'h55aa, 16'h9669, 16'h0ff0, 16'ha5c3};
  localparam logic [7:0][1:0]  WM = {2'h3, 2'h0, 2'h2, 2'h3,
    2'h1, 2'h3, 2'h2, 2'h1};
  logic        sys_clk, link_clk, rst_n, term_en, rd_valid;
  logic        dq_oe, lm_o, lm_oe, um_o, um_oe, wr_valid, scv, sovr;
  logic        lm_line, um_line;
  logic [15:0] rd_data, dut_dq, ctrl_dq, dq_line;
  logic [13:0] mr1, mr5;
  logic [1:0]  ctrl_mask;
  spd_pins_t   pins;
  spd_dec_t    dec, scmd;
  spd_term_t   term;
  spd_wr_t     wr_beats;
  spd_wr_t     got [8];
  int          n_got, error_cnt, samples_checked, cycles;
  spd_cmd_t    tab [8] = '{SPD_MRS, SPD_REF, SPD_PRE, SPD_RSVD,
                           SPD_WR, SPD_RD, SPD_ZQC, SPD_NOP};

  // Shared pins resolve from the drivers' enables
  assign dq_line = dq_oe ? dut_dq : ctrl_dq;
  assign lm_line = lm_oe ? lm_o : ctrl_mask[0];
  assign um_line = um_oe ? um_o : ctrl_mask[1];

  spd_ctrl_model ctrl (.clk_i(link_clk), .pins_o(pins), .dq_o(ctrl_dq),
    .mask_n_o(ctrl_mask));

  spd_pin_decode dut (.sys_clk_i(sys_clk), .link_clk_i(link_clk),
    .rst_n_i(rst_n), .cke_i(pins.cke), .chip_sel_n_i(pins.cs_n),
    .row_open_strobe_n_i(pins.act_n), .cmd_bit_row_hi_i(pins.row_hi),
    .cmd_bit_col_i(pins.col), .cmd_bit_store_i(pins.store),
    .group_select_i(pins.group), .group_select_hi_i(1'b1),
    .bank_select_i(pins.bank), .addr_i(pins.addr),
    .die_termination_enable_i(term_en), .dq_i(dq_line), .dq_o(dut_dq),
    .dq_oe_o(dq_oe), .lower_byte_mask_n_i(lm_line),
    .lower_byte_mask_n_o(lm_o), .lower_byte_mask_oe_o(lm_oe),
    .upper_byte_mask_n_i(um_line), .upper_byte_mask_n_o(um_o),
    .upper_byte_mask_oe_o(um_oe), .dec_o(dec), .term_o(term),
    .wr_valid_o(wr_valid), .wr_beats_o(wr_beats), .rd_valid_i(rd_valid),
    .rd_data_i(rd_data), .mode_reg_one_o(mr1), .mode_reg_five_o(mr5),
    .sys_cmd_valid_o(scv), .sys_cmd_o(scmd), .sys_overrun_o(sovr));

  // ====
  // Clocks, pair monitor, hang guard
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Offset start keeps the two clocks unrelated in phase
  initial begin
    link_clk = 1'b0;
    #7;
    forever #32 link_clk = ~link_clk;
  end
  always @(posedge link_clk)
    if (wr_valid === 1'b1 && n_got < 8) begin
      got[n_got] = wr_beats;
      n_got++;
    end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // ====
  // Tasks
  task automatic give_verdict();
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input string name, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic spd_pins_t mk(input logic ck, cs, act,
      input logic [2:0] c, input logic [2:0] sel, input logic [13:0] a);
    return '{ck, cs, act, c[2], c[1], c[0], sel[2], sel[1:0], a};
  endfunction
  task automatic chk_dec(input spd_pins_t p, input spd_cmd_t e);
    ctrl.cmd(p);
    cmp("cmd", e, dec.cmd);
    if (e inside {SPD_ACT, SPD_RD, SPD_WR, SPD_PRE})
      cmp("grp", {p.group, p.bank}, {dec.group, dec.bank});
    if (e == SPD_ACT)
      cmp("row", {p.row_hi, p.col, p.store, p.addr}, dec.row);
    if (e inside {SPD_RD, SPD_WR})
      cmp("col", p.addr[12:0], {dec.burst_full, 1'b0, dec.auto_close,
          dec.col} | {1'b0, p.addr[11], 11'h0});
    if (e == SPD_MRS)
      cmp("mrs", {p.group, p.bank, p.addr}, {dec.mr_sel, dec.opcode});
  endtask
  task automatic set_mr(input logic [2:0] sel, input logic [13:0] v);
    ctrl.cmd(mk(1, 0, 1, 3'h0, sel, v));
    @(posedge link_clk);
    #1;
  endtask
  task automatic wr_test(input logic [13:0] a, input logic [13:0] v);
    int np;
    logic pin, inv, msk;
    logic [7:0] byt;
    np = a[12] ? 4 : 2;
    n_got = 0;
    ctrl.cmd(mk(1, 0, 1, 3'h4, 3'h2, a));
    ctrl.wr_data(WD, WM, 2 * np);
    repeat (3) @(posedge link_clk);
    #1;
    cmp("pairs", np, n_got);
    for (int k = 0; k < np; k++)
      for (int j = 0; j < 4; j++) begin
        pin = WM[2 * k + j / 2][j % 2];
        byt = WD[2 * k + j / 2][8 * (j % 2) +: 8];
        inv = v[11] & ~pin;
        msk = v[10] & ~pin & ~v[11];
        cmp("be", !msk, got[k].be[j]);
        if (!msk)
          cmp("byte", byt ^ {8{inv}}, got[k].data[j / 2][8 * (j % 2) +: 8]);
      end
  endtask
  task automatic rd_test(input logic [15:0] d, input logic [13:0] v);
    logic inv;
    @(posedge link_clk);
    #2;
    rd_valid = 1'b1;
    rd_data  = d;
    @(posedge link_clk);
    #1;
    cmp("rd_oe", 1'b1, dq_oe);
    for (int b = 0; b < 2; b++) begin
      inv = v[12] && ($countones(~d[8 * b +: 8]) > 4);
      cmp("rd_byte", d[8 * b +: 8] ^ {8{inv}}, dq_line[8 * b +: 8]);
      if (v[12])
        cmp("rd_flag", !inv, b ? um_line : lm_line);
    end
    #1;
    rd_valid = 1'b0;
    @(posedge link_clk);
    #1;
    cmp("rd_oe_off", 1'b0, dq_oe);
  endtask

  // ====
  // Main sequence
  initial begin
    rst_n    = 1'b0;
    term_en  = 1'b0;
    rd_valid = 1'b0;
    rd_data  = 16'h0000;
    repeat (4) @(posedge sys_clk);
    #2;
    rst_n = 1'b1;
    @(posedge link_clk);
    #1;
    cmp("mr_rst", 28'h0, {mr1, mr5});
    cmp("flag_rst", 2'h3, {lm_o, um_o});
    for (int c = 0; c < 8; c++)
      chk_dec(mk(1, 0, 1, c, c, {c[2:0], 11'h2a5}), tab[c]);
    chk_dec(mk(1, 0, 1, 3'h2, 3'h6, 14'h0400), SPD_PREA);
    chk_dec(mk(1, 0, 0, 3'h5, 3'h6, 14'h3a5c), SPD_ACT);
    chk_dec(mk(1, 1, 0, 3'h5, 3'h6, 14'h3a5c), SPD_NONE);
    chk_dec(mk(1, 1, 1, 3'h4, 3'h1, 14'h1234), SPD_NONE);
    chk_dec(mk(0, 0, 1, 3'h5, 3'h1, 14'h1234), SPD_NONE);
    chk_dec(mk(1, 0, 1, 3'h5, 3'h3, 14'h05a3), SPD_RD);
    chk_dec(mk(1, 0, 1, 3'h4, 3'h7, 14'h1234), SPD_WR);
    #1;
    term_en = 1'b1;
    @(posedge link_clk);
    #1;
    cmp("term_off", 20'h0, term);
    set_mr(3'h1, 14'h0100);
    cmp("mr1", 14'h0100, mr1);
    set_mr(3'h3, 14'h3fff);
    cmp("mr_keep", {14'h0100, 14'h0000}, {mr1, mr5});
    cmp("term_on", 20'hfffff, term);
    #1;
    term_en = 1'b0;
    @(posedge link_clk);
    #1;
    cmp("term_drop", 20'h0, term);
    set_mr(3'h5, 14'h0400);
    wr_test(14'h1000, 14'h0400);
    set_mr(3'h5, 14'h0800);
    wr_test(14'h0000, 14'h0800);
    set_mr(3'h5, 14'h0c00);
    wr_test(14'h1000, 14'h0c00);
    set_mr(3'h5, 14'h1000);
    rd_test(16'h0f00, 14'h1000);
    rd_test(16'he01f, 14'h1000);
    set_mr(3'h5, 14'h0000);
    rd_test(16'h00f0, 14'h0000);
    // Reset lands mid-cycle, away from both clock edges
    @(posedge sys_clk);
    #30;
    rst_n = 1'b0;
    #1;
    cmp("mr_async", 28'h0, {mr1, mr5});
    cmp("ovr_rst", 1'b0, sovr);
    repeat (4) @(posedge sys_clk);
    #2;
    rst_n = 1'b1;
    ctrl.cmd(mk(1, 0, 0, 3'h3, 3'h2, 14'h0abc));
    for (int i = 0; i < 40 && scv !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    cmp("sys_cmd", SPD_ACT, scmd.cmd);
    cmp("sys_row", 17'h0cabc, scmd.row);
    cmp("sys_ovr0", 1'b0, sovr);
    ctrl.cmd(mk(1, 0, 1, 3'h5, 3'h1, 14'h0010));
    ctrl.cmd(mk(1, 0, 1, 3'h4, 3'h1, 14'h1010));
    repeat (10) @(posedge sys_clk);
    #1;
    cmp("sys_ovr1", 1'b1, sovr);
    give_verdict();
  end
endmodule // testbench
